/* File: hw/tw_pkg.sv */
package tw_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_DATA = 8'h9A;
    localparam logic [7:0] ADDR_OWN  = 8'h9B;
    localparam logic [7:0] ADDR_CTRL = 8'hE8;

    localparam logic [7:0] RST_DATA  = 8'h00;
    localparam logic [7:0] RST_OWN   = 8'h55;
    localparam logic [7:0] RST_CTRL  = 8'h00;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int unsigned B_SDO  = 7;
    localparam int unsigned B_SDE  = 6;
    localparam int unsigned B_SCO  = 5;
    localparam int unsigned B_SDI  = 4;
    localparam int unsigned B_MSEL = 3;
    localparam int unsigned B_IRST = 2;
    localparam int unsigned B_TX   = 1;
    localparam int unsigned B_DONE = 0;

    localparam logic [2:0] LAST_BIT = 3'h7;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_DATA = 3'b010,
        ST_DACK = 3'b110
    } slave_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

endpackage : tw_pkg

/* File: hw/two_wire_slave_and_bitbang_master.sv */
// Function
// - In software master mode the data-output bit is driven on the data pin while data drive is enabled.
// - The data drive enable makes the data pin an output when set and an input when clear, in master mode.
// - In software master mode the clock-output bit is driven on the clock pin.
// - In master mode with data drive off, the data pin level is caught into the data-input bit on the clock.
// - The master select bit picks software master when 1 and hardware slave when 0.
// - In slave mode the interface reset bit holds the interface in reset until cleared.
// - In slave mode the direction bit is set while transmitting and cleared while receiving.
// - In slave mode the byte-done flag is set after each whole data byte sent or received, not after the address byte.
// - An access to the data register clears the byte-done flag and its pending request.
// - The own-address register holds the answered slave address, resets to 55h and is writable.
// - Writing the data register gives the next byte to send, reading gives the last received; reset 00h.
// - The interface is active only while the serial peripheral select is clear.
module two_wire_slave_and_bitbang_master (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             link_clk,
    input  wire tw_pkg::sfr_req_s sfr_req,
    input  wire logic             spi_select,
    input  wire logic             serial_data_pin_i,
    input  wire logic             serial_clock_pin_i,
    output wire logic [7:0]       sfr_rdata,
    output wire logic             serial_data_pin_o,
    output wire logic             serial_data_pin_oe_n,
    output wire logic             serial_clock_pin_o,
    output wire logic             serial_clock_pin_oe_n,
    output wire logic             byte_done_irq
);

    // ****************************************
    // link domain: catch data on each clock-pin rise
    // ****************************************
    logic lrst1_reg, lrst2_reg;
    logic lscl1_reg, lscl2_reg, lscl_prev_reg;
    logic lsda1_reg, lsda2_reg;
    logic link_bit_reg;
    logic link_tgl_reg;

    // free-running link clock oversamples both pins, so reset syncs even with a still bus
    always_ff @(posedge link_clk)
    begin
        lrst1_reg <= nrst;
        lrst2_reg <= lrst1_reg;
        lscl1_reg <= serial_clock_pin_i;
        lscl2_reg <= lscl1_reg;
        lsda1_reg <= serial_data_pin_i;
        lsda2_reg <= lsda1_reg;
    end

    // prev tracks the pin through reset, so no false rise follows it
    always_ff @(posedge link_clk)
    begin
        lscl_prev_reg <= lscl2_reg;
    end

    // the bit is held until the next rise, so the toggle alone needs syncing
    always_ff @(posedge link_clk)
    begin
        if (!lrst2_reg)
        begin
            link_bit_reg <= 1'b0;
            link_tgl_reg <= 1'b0;
        end
        else if (lscl2_reg && !lscl_prev_reg)
        begin
            link_bit_reg <= lsda2_reg;
            link_tgl_reg <= ~link_tgl_reg;
        end
    end

    // ****************************************
    // core domain synchronisers
    // ****************************************
    logic tgl_s1_reg, tgl_s2_reg, tgl_prev_reg;
    logic sda_s1_reg, sda_s2_reg, sda_prev_reg;
    logic scl_s1_reg, scl_s2_reg, scl_prev_reg;

    always_ff @(posedge clk)
    begin
        tgl_s1_reg <= link_tgl_reg;
        tgl_s2_reg <= tgl_s1_reg;
        sda_s1_reg <= serial_data_pin_i;
        sda_s2_reg <= sda_s1_reg;
        scl_s1_reg <= serial_clock_pin_i;
        scl_s2_reg <= scl_s1_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tgl_prev_reg <= tgl_s2_reg;
            sda_prev_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
        end
        else
        begin
            tgl_prev_reg <= tgl_s2_reg;
            sda_prev_reg <= sda_s2_reg;
            scl_prev_reg <= scl_s2_reg;
        end
    end

    // ****************************************
    // registers and events
    // ****************************************
    logic                 sda_out_bit_reg, sda_drive_en_reg, scl_out_bit_reg, sda_in_bit_reg;
    logic                 master_select_reg, iface_reset_reg, slave_tx_dir_reg, byte_done_flag_reg;
    logic [7:0]           own_address_reg, bus_data_reg, rdata_reg, rx_sh_reg, tx_sh_reg;
    logic [2:0]           cnt_reg;
    logic                 sda_low_reg;
    logic                 sda_o_reg, sda_oe_n_reg, scl_o_reg, scl_oe_n_reg;
    tw_pkg::slave_state_e st_reg;

    logic active, slave_run, rise_ev, fall_ev, start_ev, stop_ev, last_bit, addr_hit, byte_end;
    logic ctrl_wr, data_acc;

    assign active    = ~spi_select;
    assign slave_run = active & ~master_select_reg & ~iface_reset_reg;
    assign rise_ev   = tgl_s2_reg ^ tgl_prev_reg;
    assign fall_ev   = scl_prev_reg & ~scl_s2_reg;
    assign start_ev  = scl_s2_reg & scl_prev_reg & sda_prev_reg & ~sda_s2_reg;
    assign stop_ev   = scl_s2_reg & scl_prev_reg & ~sda_prev_reg & sda_s2_reg;
    assign last_bit  = cnt_reg == tw_pkg::LAST_BIT;
    assign addr_hit  = rx_sh_reg[6:0] == own_address_reg[6:0];
    assign byte_end  = slave_run & rise_ev & last_bit & (st_reg == tw_pkg::ST_DATA);
    assign ctrl_wr   = sfr_req.wr & (sfr_req.addr == tw_pkg::ADDR_CTRL);
    assign data_acc  = (sfr_req.wr | sfr_req.rd) & (sfr_req.addr == tw_pkg::ADDR_DATA);

    // ****************************************
    // software control bits
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sda_out_bit_reg   <= tw_pkg::RST_CTRL[tw_pkg::B_SDO];
            sda_drive_en_reg  <= tw_pkg::RST_CTRL[tw_pkg::B_SDE];
            scl_out_bit_reg   <= tw_pkg::RST_CTRL[tw_pkg::B_SCO];
            master_select_reg <= tw_pkg::RST_CTRL[tw_pkg::B_MSEL];
            iface_reset_reg   <= tw_pkg::RST_CTRL[tw_pkg::B_IRST];
        end
        else if (ctrl_wr)
        begin
            sda_out_bit_reg   <= sfr_req.wdata[tw_pkg::B_SDO];
            sda_drive_en_reg  <= sfr_req.wdata[tw_pkg::B_SDE];
            scl_out_bit_reg   <= sfr_req.wdata[tw_pkg::B_SCO];
            master_select_reg <= sfr_req.wdata[tw_pkg::B_MSEL];
            iface_reset_reg   <= sfr_req.wdata[tw_pkg::B_IRST];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            own_address_reg <= tw_pkg::RST_OWN;
        else if (sfr_req.wr && sfr_req.addr == tw_pkg::ADDR_OWN)
            own_address_reg <= sfr_req.wdata;
    end

    // received byte beats a software write in the same cycle
    always_ff @(posedge clk)
    begin
        if (!nrst)
            bus_data_reg <= tw_pkg::RST_DATA;
        else if (byte_end && !slave_tx_dir_reg)
            bus_data_reg <= {rx_sh_reg[6:0], link_bit_reg};
        else if (sfr_req.wr && sfr_req.addr == tw_pkg::ADDR_DATA)
            bus_data_reg <= sfr_req.wdata;
    end

    // set wins over the access that clears
    always_ff @(posedge clk)
    begin
        if (!nrst)
            byte_done_flag_reg <= 1'b0;
        else if (byte_end)
            byte_done_flag_reg <= 1'b1;
        else if (data_acc)
            byte_done_flag_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            sda_in_bit_reg <= 1'b0;
        else if (active && master_select_reg && !sda_drive_en_reg && rise_ev)
            sda_in_bit_reg <= link_bit_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata_reg <= 8'h00;
        else if (sfr_req.rd)
        begin
            unique case (sfr_req.addr)
                tw_pkg::ADDR_DATA: rdata_reg <= bus_data_reg;
                tw_pkg::ADDR_OWN:  rdata_reg <= own_address_reg;
                tw_pkg::ADDR_CTRL: rdata_reg <= {sda_out_bit_reg, sda_drive_en_reg, scl_out_bit_reg,
                                                 sda_in_bit_reg, master_select_reg, iface_reset_reg,
                                                 slave_tx_dir_reg, byte_done_flag_reg};
                default:           rdata_reg <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // hardware slave
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!nrst || !slave_run)
        begin
            st_reg  <= tw_pkg::ST_IDLE;
            cnt_reg <= 3'h0;
        end
        else if (start_ev)
        begin
            st_reg  <= tw_pkg::ST_ADDR;
            cnt_reg <= 3'h0;
        end
        else if (stop_ev)
            st_reg <= tw_pkg::ST_IDLE;
        else if (rise_ev)
        begin
            unique case (st_reg)
                tw_pkg::ST_IDLE: st_reg <= tw_pkg::ST_IDLE;
                tw_pkg::ST_ADDR:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (last_bit)
                        st_reg <= addr_hit ? tw_pkg::ST_AACK : tw_pkg::ST_IDLE;
                end
                tw_pkg::ST_AACK:
                begin
                    st_reg  <= tw_pkg::ST_DATA;
                    cnt_reg <= 3'h0;
                end
                tw_pkg::ST_DATA:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (last_bit)
                        st_reg <= tw_pkg::ST_DACK;
                end
                tw_pkg::ST_DACK:
                begin
                    // a not-acknowledge from the master ends a read
                    st_reg  <= (slave_tx_dir_reg && link_bit_reg) ? tw_pkg::ST_IDLE : tw_pkg::ST_DATA;
                    cnt_reg <= 3'h0;
                end
                default: st_reg <= tw_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rx_sh_reg <= 8'h00;
        else if (rise_ev)
            rx_sh_reg <= {rx_sh_reg[6:0], link_bit_reg};
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            slave_tx_dir_reg <= 1'b0;
        else if (slave_run && rise_ev && last_bit && st_reg == tw_pkg::ST_ADDR && addr_hit)
            slave_tx_dir_reg <= link_bit_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            tx_sh_reg <= 8'h00;
        else if (rise_ev && (st_reg == tw_pkg::ST_AACK || st_reg == tw_pkg::ST_DACK))
            tx_sh_reg <= bus_data_reg;
        else if (rise_ev && st_reg == tw_pkg::ST_DATA)
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end

    // data changes only while the clock is low
    always_ff @(posedge clk)
    begin
        if (!nrst || !slave_run || start_ev || stop_ev)
            sda_low_reg <= 1'b0;
        else if (fall_ev)
            sda_low_reg <= (st_reg == tw_pkg::ST_AACK)
                         | (st_reg == tw_pkg::ST_DACK & ~slave_tx_dir_reg)
                         | (st_reg == tw_pkg::ST_DATA & slave_tx_dir_reg & ~tx_sh_reg[7]);
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!nrst || !active)
        begin
            sda_o_reg    <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            scl_o_reg    <= 1'b1;
            scl_oe_n_reg <= 1'b1;
        end
        else if (master_select_reg)
        begin
            sda_o_reg    <= sda_out_bit_reg;
            sda_oe_n_reg <= ~sda_drive_en_reg;
            scl_o_reg    <= scl_out_bit_reg;
            scl_oe_n_reg <= 1'b0;
        end
        else
        begin
            sda_o_reg    <= 1'b0;
            sda_oe_n_reg <= ~sda_low_reg;
            scl_o_reg    <= 1'b1;
            scl_oe_n_reg <= 1'b1;
        end
    end

    assign sfr_rdata             = rdata_reg;
    assign serial_data_pin_o     = sda_o_reg;
    assign serial_data_pin_oe_n  = sda_oe_n_reg;
    assign serial_clock_pin_o    = scl_o_reg;
    assign serial_clock_pin_oe_n = scl_oe_n_reg;
    assign byte_done_irq         = byte_done_flag_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic mst_act;
    assign mst_act = active & master_select_reg;

    sequence s_addr_hit;
        slave_run && rise_ev && !start_ev && !stop_ev && last_bit && st_reg == tw_pkg::ST_ADDR && addr_hit;
    endsequence
    sequence s_addr_miss;
        slave_run && rise_ev && !start_ev && !stop_ev && last_bit && st_reg == tw_pkg::ST_ADDR && !addr_hit;
    endsequence

    property p_sda_out;
        mst_act && sda_drive_en_reg |=> !sda_oe_n_reg && sda_o_reg == $past(sda_out_bit_reg);
    endproperty
    a_sda_out: assert property (p_sda_out) else $error("data pin not driven");

    property p_sda_dir;
        mst_act && !sda_drive_en_reg |=> sda_oe_n_reg;
    endproperty
    a_sda_dir: assert property (p_sda_dir) else $error("data pin not released");

    property p_scl_out;
        mst_act |=> !scl_oe_n_reg && scl_o_reg == $past(scl_out_bit_reg);
    endproperty
    a_scl_out: assert property (p_scl_out) else $error("clock pin wrong");

    property p_sda_in;
        mst_act && !sda_drive_en_reg && rise_ev |=> sda_in_bit_reg == $past(link_bit_reg);
    endproperty
    a_sda_in: assert property (p_sda_in) else $error("data input not caught");

    property p_slave_clk;
        active && !master_select_reg |=> scl_oe_n_reg;
    endproperty
    a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");

    property p_irst;
        !master_select_reg && iface_reset_reg |=> st_reg == tw_pkg::ST_IDLE ##1 sda_oe_n_reg;
    endproperty
    a_irst: assert property (p_irst) else $error("reset bit ignored");

    property p_dir;
        s_addr_hit |=> st_reg == tw_pkg::ST_AACK && slave_tx_dir_reg == $past(link_bit_reg);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_done;
        byte_end |=> byte_done_flag_reg && byte_done_irq;
    endproperty
    a_done: assert property (p_done) else $error("flag not set");

    property p_clr;
        data_acc && !byte_end |=> !byte_done_flag_reg;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");

    property p_own;
        sfr_req.wr && sfr_req.addr == tw_pkg::ADDR_OWN |=> own_address_reg == $past(sfr_req.wdata);
    endproperty
    a_own: assert property (p_own) else $error("own address not written");

    property p_rd;
        sfr_req.rd && sfr_req.addr == tw_pkg::ADDR_DATA |=> sfr_rdata == $past(bus_data_reg);
    endproperty
    a_rd: assert property (p_rd) else $error("data read wrong");

    property p_spi;
        spi_select |=> sda_oe_n_reg && scl_oe_n_reg;
    endproperty
    a_spi: assert property (p_spi) else $error("pins driven while shared");

    property p_miss;
        s_addr_miss |=> st_reg == tw_pkg::ST_IDLE ##1 !sda_low_reg;
    endproperty
    a_miss: assert property (p_miss) else $error("answered foreign address");

endmodule : two_wire_slave_and_bitbang_master

/* File: verif/two_wire_master_model.sv */
// ****************************************
// far-end bus master, bit timing from 6 ns tick
// ****************************************
module two_wire_master_model (
    output logic     scl_drv,
    output logic     sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic tick;

    initial
    begin
        tick    = 1'b0;
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        forever #3 tick = ~tick;
    end

    // 10 ticks per phase keeps each level above the 48 ns the slave needs
    task automatic phase(input int n);
        repeat (n) @(posedge tick);
    endtask : phase

    task automatic hold_sda(input logic v);
        sda_drv = v;
    endtask : hold_sda

    task automatic start;
        sda_drv = 1'b1;
        scl_drv = 1'b1;
        phase(10);
        sda_drv = 1'b0;
        phase(10);
        scl_drv = 1'b0;
    endtask : start

    task automatic stop;
        sda_drv = 1'b0;
        phase(10);
        scl_drv = 1'b1;
        phase(10);
        sda_drv = 1'b1;
        phase(10);
    endtask : stop

    // released data goes to the pull-up, never a stale value
    task automatic clock_bit(input logic b, output logic s);
        sda_drv = b;
        phase(10);
        scl_drv = 1'b1;
        phase(5);
        s = sda_line;
        phase(5);
        scl_drv = 1'b0;
    endtask : clock_bit

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], s);
        clock_bit(1'b1, ack);
    endtask : write_byte

    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, d[i]);
        clock_bit(nack, s);
    endtask : read_byte

endmodule : two_wire_master_model

/* File: verif/two_wire_slave_and_bitbang_master_bench.sv */
module two_wire_slave_and_bitbang_master_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic             clk;
    logic             link_clk;
    logic             nrst;
    logic             spi_select;
    tw_pkg::sfr_req_s sfr_req;
    logic [7:0]       sfr_rdata;
    logic             sda_o;
    logic             sda_oe_n;
    logic             scl_o;
    logic             scl_oe_n;
    logic             irq;
    logic             p_scl;
    logic             p_sda;
    logic [7:0]       v;
    logic             ack;
    int               fail_count;
    int               check_count;

    // ****************************************
    // wired-and pins with pull-ups
    // ****************************************
    wire logic sda_line = (sda_oe_n ? 1'b1 : sda_o) & p_sda;
    wire logic scl_line = (scl_oe_n ? 1'b1 : scl_o) & p_scl;

    two_wire_slave_and_bitbang_master two_wire_slave_and_bitbang_master_i (
        .clk                   (clk),
        .nrst                  (nrst),
        .link_clk              (link_clk),
        .sfr_req               (sfr_req),
        .spi_select            (spi_select),
        .serial_data_pin_i     (sda_line),
        .serial_clock_pin_i    (scl_line),
        .sfr_rdata             (sfr_rdata),
        .serial_data_pin_o     (sda_o),
        .serial_data_pin_oe_n  (sda_oe_n),
        .serial_clock_pin_o    (scl_o),
        .serial_clock_pin_oe_n (scl_oe_n),
        .byte_done_irq         (irq)
    );

    two_wire_master_model two_wire_master_model_i (
        .scl_drv  (p_scl),
        .sda_drv  (p_sda),
        .sda_line (sda_line)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic summarize;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        wait_clk(1);
        sfr_req.wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        wait_clk(1);
        sfr_req.rd = 1'b0;
        d = sfr_rdata;
    endtask : reg_read

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] d;
        reg_read(a, d);
        check(d & mask, exp);
    endtask : expect_reg

    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // link clock, 6 ns, phase unrelated to clk
    initial
    begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        nrst        = 1'b0;
        spi_select  = 1'b0;
        sfr_req     = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        fail_count  = 0;
        check_count = 0;
        wait_clk(10);
        nrst = 1'b1;
        expect_reg(tw_pkg::ADDR_DATA, 8'hFF, 8'h00);
        expect_reg(tw_pkg::ADDR_OWN, 8'hFF, 8'h55);
        expect_reg(tw_pkg::ADDR_CTRL, 8'hFF, 8'h00);
        reg_write(8'h10, 8'hA5);
        expect_reg(8'h10, 8'hFF, 8'h00);
        reg_write(tw_pkg::ADDR_OWN, 8'h3A);
        expect_reg(tw_pkg::ADDR_OWN, 8'hFF, 8'h3A);
        // bit-bang master: pins follow the control bits
        reg_write(tw_pkg::ADDR_CTRL, 8'hE8);
        wait_clk(2);
        check({4'h0, sda_o, sda_oe_n, scl_o, scl_oe_n}, 8'h0A);
        reg_write(tw_pkg::ADDR_CTRL, 8'h48);
        wait_clk(2);
        check({4'h0, sda_o, sda_oe_n, scl_o, scl_oe_n}, 8'h00);
        reg_write(tw_pkg::ADDR_CTRL, 8'h08);
        wait_clk(2);
        check({6'h00, sda_oe_n, scl_oe_n}, 8'h02);
        two_wire_master_model_i.hold_sda(1'b1);
        reg_write(tw_pkg::ADDR_CTRL, 8'h28);
        wait_clk(8);
        expect_reg(tw_pkg::ADDR_CTRL, 8'hFF, 8'h38);
        reg_write(tw_pkg::ADDR_CTRL, 8'h08);
        two_wire_master_model_i.hold_sda(1'b0);
        reg_write(tw_pkg::ADDR_CTRL, 8'h28);
        wait_clk(8);
        expect_reg(tw_pkg::ADDR_CTRL, 8'hFF, 8'h28);
        two_wire_master_model_i.hold_sda(1'b1);
        spi_select = 1'b1;
        wait_clk(3);
        check({6'h00, sda_oe_n, scl_oe_n}, 8'h03);
        spi_select = 1'b0;
        // hardware slave receive
        reg_write(tw_pkg::ADDR_CTRL, 8'h00);
        two_wire_master_model_i.start();
        two_wire_master_model_i.write_byte(8'h74, ack);
        check({7'h00, ack}, 8'h00);
        expect_reg(tw_pkg::ADDR_CTRL, 8'h02, 8'h00);
        two_wire_master_model_i.write_byte(8'hC5, ack);
        wait_clk(2);
        check({7'h00, irq}, 8'h01);
        expect_reg(tw_pkg::ADDR_DATA, 8'hFF, 8'hC5);
        check({7'h00, irq}, 8'h00);
        two_wire_master_model_i.stop();
        // hardware slave transmit, master ends with a nack
        reg_write(tw_pkg::ADDR_DATA, 8'h96);
        two_wire_master_model_i.start();
        two_wire_master_model_i.write_byte(8'h75, ack);
        check({7'h00, ack}, 8'h00);
        expect_reg(tw_pkg::ADDR_CTRL, 8'h02, 8'h02);
        two_wire_master_model_i.read_byte(1'b1, v);
        check(v, 8'h96);
        check({7'h00, irq}, 8'h01);
        two_wire_master_model_i.stop();
        reg_read(tw_pkg::ADDR_DATA, v);
        // foreign address is ignored
        two_wire_master_model_i.start();
        two_wire_master_model_i.write_byte(8'h22, ack);
        check({7'h00, ack}, 8'h01);
        two_wire_master_model_i.stop();
        // held in reset, then back to normal
        reg_write(tw_pkg::ADDR_CTRL, 8'h04);
        two_wire_master_model_i.start();
        two_wire_master_model_i.write_byte(8'h74, ack);
        check({7'h00, ack}, 8'h01);
        two_wire_master_model_i.stop();
        reg_write(tw_pkg::ADDR_CTRL, 8'h00);
        two_wire_master_model_i.start();
        two_wire_master_model_i.write_byte(8'h74, ack);
        check({7'h00, ack}, 8'h00);
        two_wire_master_model_i.stop();
        summarize();
    end

endmodule : two_wire_slave_and_bitbang_master_bench
